// ---- core/iotrim_core.sv ----
// Purpose: Closed-loop trim of the internal fast oscillator, AHB-Lite registers.
// Assumes: Reference ticks and divided oscillator pulses arrive asynchronously.
// Notes:   Zero wait states; OKAY response always.
`timescale 1ns/1ps
`include "iotrim_defs.svh"

module iotrim_core (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Reference and oscillator pins
    input  wire logic        usb_ref_tick,
    input  wire logic        secondary_oscillator,
    input  wire logic        osc_div_tick,
    // Power state and outputs
    input  wire logic        sleep_mode,
    output logic      [6:0]  trim_value,
    output logic             tuning_irq
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    logic        ahb_wr_reg;
    logic        ahb_wr_next;
    logic [5:0]  ahb_addr_reg;
    logic [5:0]  ahb_addr_next;
    logic [31:0] hrdata_reg;
    logic [31:0] hrdata_next;

    logic        tuning_enable_reg;
    logic        tuning_enable_next;
    logic        tuning_update_hold_reg;
    logic        tuning_update_hold_next;
    logic        reference_select_reg;
    logic        reference_select_next;
    logic        tuning_locked_reg;
    logic        tuning_locked_next;
    logic        tuning_out_of_range_reg;
    logic        tuning_out_of_range_next;
    logic        tuning_event_flag_reg;
    logic        tuning_event_flag_next;
    logic        tuning_event_irq_enable_reg;
    logic        tuning_event_irq_enable_next;
    iotrim_pkg::iotrim_trim_t trim_reg;
    iotrim_pkg::iotrim_trim_t trim_next;
    iotrim_pkg::iotrim_cnt_t  osc_count_reg;
    iotrim_pkg::iotrim_cnt_t  osc_count_next;

    logic [2:0]  ref_sync_reg;
    logic [2:0]  osc_sync_reg;
    logic        ref_raw;
    logic        ref_strobe;
    logic        osc_pulse;
    logic        running;
    logic        addr_phase;
    logic        data_wr;
    iotrim_pkg::iotrim_cnt_t  target;
    iotrim_pkg::iotrim_cnt_t  tol;
    iotrim_pkg::iotrim_verdict_e verdict;

    ////////////////////////////////////////////////////////////////////////
    // Bus slave: always ready, never errors

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_reg;
    assign addr_phase = hsel && hready && htrans[1];
    assign data_wr    = ahb_wr_reg;

    // Latch the address phase; a read word is fetched here so it stands in the data phase
    always_comb begin
        ahb_wr_next   = addr_phase && hwrite;
        ahb_addr_next = addr_phase ? haddr[5:0] : ahb_addr_reg;
        hrdata_next   = 32'h0000_0000;
        if (addr_phase && !hwrite) begin
            case (haddr[5:0])
                `IOTRIM_OFS_CONTROL: begin
                    hrdata_next[`IOTRIM_BIT_ENABLE] = tuning_enable_reg;
                    hrdata_next[`IOTRIM_BIT_HOLD]   = tuning_update_hold_reg;
                    hrdata_next[`IOTRIM_BIT_SELECT] = reference_select_reg;
                    hrdata_next[`IOTRIM_BIT_LOCKED] = tuning_locked_reg;
                    hrdata_next[`IOTRIM_BIT_RANGE]  = tuning_out_of_range_reg;
                end
                `IOTRIM_OFS_TRIM:   hrdata_next[6:0] = trim_reg;
                `IOTRIM_OFS_FLAG:   hrdata_next[`IOTRIM_BIT_EVENT] = tuning_event_flag_reg;
                `IOTRIM_OFS_IRQ_EN: hrdata_next[`IOTRIM_BIT_EVENT] = tuning_event_irq_enable_reg;
                default:            hrdata_next = 32'h0000_0000;
            endcase
        end
    end

    // Bus phase registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ahb_wr_reg   <= 1'b0;
            ahb_addr_reg <= 6'h00;
            hrdata_reg   <= 32'h0000_0000;
        end else begin
            ahb_wr_reg   <= ahb_wr_next;
            ahb_addr_reg <= ahb_addr_next;
            hrdata_reg   <= hrdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; only stage two and three are read

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ref_sync_reg <= 3'h0;
            osc_sync_reg <= 3'h0;
        end else begin
            ref_sync_reg <= {ref_sync_reg[1:0], ref_raw};
            osc_sync_reg <= {osc_sync_reg[1:0], osc_div_tick};
        end
    end

    // Select is steered before the synchroniser; changing it live may fake one edge
    assign ref_raw    = reference_select_reg ? usb_ref_tick : secondary_oscillator;
    assign ref_strobe = ref_sync_reg[1] && !ref_sync_reg[2];
    assign osc_pulse  = osc_sync_reg[1] && !osc_sync_reg[2];
    assign running    = tuning_enable_reg && !sleep_mode;

    ////////////////////////////////////////////////////////////////////////
    // Compare the oscillator count with the window of the selected source

    always_comb begin
        target  = reference_select_reg ? `IOTRIM_USB_TARGET : `IOTRIM_SEC_TARGET;
        tol     = reference_select_reg ? `IOTRIM_USB_TOL : `IOTRIM_SEC_TOL;
        verdict = iotrim_pkg::IOTRIM_IN_WINDOW;
        if (osc_count_reg < target - tol) begin
            verdict = iotrim_pkg::IOTRIM_TOO_SLOW;
        end else if (osc_count_reg > target + tol) begin
            verdict = iotrim_pkg::IOTRIM_TOO_FAST;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Tuning and register next state

    always_comb begin
        tuning_enable_next           = tuning_enable_reg;
        tuning_update_hold_next      = tuning_update_hold_reg;
        reference_select_next        = reference_select_reg;
        tuning_locked_next           = tuning_locked_reg;
        tuning_out_of_range_next     = tuning_out_of_range_reg;
        tuning_event_irq_enable_next = tuning_event_irq_enable_reg;
        trim_next                    = trim_reg;
        osc_count_next               = osc_count_reg;
        tuning_event_flag_next       = tuning_event_flag_reg;

        // Count oscillator pulses over one reference period; saturate rather than wrap
        if (running) begin
            if (ref_strobe) begin
                osc_count_next = {{(`IOTRIM_CNT_W-1){1'b0}}, osc_pulse};
            end else if (osc_pulse && osc_count_reg != {`IOTRIM_CNT_W{1'b1}}) begin
                osc_count_next = osc_count_reg + 1'b1;
            end
        end else begin
            osc_count_next = '0;
        end

        // One decision per reference tick
        if (running && ref_strobe) begin
            case (verdict)
                iotrim_pkg::IOTRIM_TOO_SLOW: begin
                    tuning_locked_next = 1'b0;
                    if (trim_reg == `IOTRIM_TRIM_MAX) begin
                        tuning_out_of_range_next = 1'b1;
                    end else if (!tuning_update_hold_reg) begin
                        trim_next = trim_reg + 1'b1;
                    end
                end
                iotrim_pkg::IOTRIM_TOO_FAST: begin
                    tuning_locked_next = 1'b0;
                    if (trim_reg == `IOTRIM_TRIM_MIN) begin
                        tuning_out_of_range_next = 1'b1;
                    end else if (!tuning_update_hold_reg) begin
                        trim_next = trim_reg - 1'b1;
                    end
                end
                default: begin
                    tuning_locked_next       = 1'b1;
                    tuning_out_of_range_next = 1'b0;
                end
            endcase
        end

        // Disable drops lock at once
        if (!tuning_enable_reg) begin
            tuning_locked_next = 1'b0;
        end

        // Software writes in the data phase
        if (data_wr) begin
            case (ahb_addr_reg)
                `IOTRIM_OFS_CONTROL: begin
                    tuning_enable_next      = hwdata[`IOTRIM_BIT_ENABLE];
                    tuning_update_hold_next = hwdata[`IOTRIM_BIT_HOLD];
                    reference_select_next   = hwdata[`IOTRIM_BIT_SELECT];
                    if (!hwdata[`IOTRIM_BIT_ENABLE]) begin
                        tuning_locked_next = 1'b0;
                    end
                end
                `IOTRIM_OFS_TRIM: begin
                    if (!tuning_enable_reg) begin
                        trim_next = hwdata[6:0];
                    end
                end
                `IOTRIM_OFS_FLAG: begin
                    if (!hwdata[`IOTRIM_BIT_EVENT]) begin
                        tuning_event_flag_next = 1'b0;
                    end
                end
                `IOTRIM_OFS_IRQ_EN: begin
                    tuning_event_irq_enable_next = hwdata[`IOTRIM_BIT_EVENT];
                end
                default: begin
                    tuning_enable_next = tuning_enable_reg;
                end
            endcase
        end

        // A status change sets the flag after any clear, so the set wins
        if ((tuning_locked_next != tuning_locked_reg)
            || (tuning_out_of_range_next != tuning_out_of_range_reg)) begin
            tuning_event_flag_next = 1'b1;
        end
    end

    // Control and status registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tuning_enable_reg           <= 1'b0;
            tuning_update_hold_reg      <= 1'b0;
            reference_select_reg        <= 1'b0;
            tuning_locked_reg           <= 1'b0;
            tuning_out_of_range_reg     <= 1'b0;
            tuning_event_flag_reg       <= 1'b0;
            tuning_event_irq_enable_reg <= 1'b0;
            trim_reg                    <= `IOTRIM_TRIM_RESET;
            osc_count_reg               <= '0;
        end else begin
            tuning_enable_reg           <= tuning_enable_next;
            tuning_update_hold_reg      <= tuning_update_hold_next;
            reference_select_reg        <= reference_select_next;
            tuning_locked_reg           <= tuning_locked_next;
            tuning_out_of_range_reg     <= tuning_out_of_range_next;
            tuning_event_flag_reg       <= tuning_event_flag_next;
            tuning_event_irq_enable_reg <= tuning_event_irq_enable_next;
            trim_reg                    <= trim_next;
            osc_count_reg               <= osc_count_next;
        end
    end

    // Outputs; the interrupt is masked in Sleep though the flag survives
    assign trim_value = trim_reg;
    assign tuning_irq = tuning_event_flag_reg && tuning_event_irq_enable_reg
                        && !sleep_mode;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    reset_disabled_a: assert property (
        @(posedge hclk) $rose(hresetn) |-> !tuning_enable_reg && !tuning_locked_reg)
        else $error("Tuning not off after reset");

    manual_trim_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        data_wr && ahb_addr_reg == `IOTRIM_OFS_TRIM && !tuning_enable_reg
        |=> trim_reg == $past(hwdata[6:0]))
        else $error("Manual trim write lost");

    trim_write_block_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        data_wr && ahb_addr_reg == `IOTRIM_OFS_TRIM && tuning_enable_reg
        && !(running && ref_strobe) |=> $stable(trim_reg))
        else $error("Trim changed by software while enabled");

    trim_step_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        running && ref_strobe && !tuning_update_hold_reg
        && verdict == iotrim_pkg::IOTRIM_TOO_SLOW && trim_reg != `IOTRIM_TRIM_MAX
        |=> trim_reg == $past(trim_reg) + 7'h01)
        else $error("Trim did not step up");

    lock_clear_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !tuning_enable_reg |=> !tuning_locked_reg)
        else $error("Lock held while disabled");

    range_limit_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        running && ref_strobe && trim_reg == `IOTRIM_TRIM_MIN
        && verdict == iotrim_pkg::IOTRIM_TOO_FAST
        |=> tuning_out_of_range_reg && trim_reg == `IOTRIM_TRIM_MIN)
        else $error("Out-of-range missed at lower limit");

    hold_freeze_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        tuning_enable_reg && tuning_update_hold_reg && !data_wr |=> $stable(trim_reg))
        else $error("Trim moved under update hold");

    event_flag_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $changed(tuning_locked_reg) || $changed(tuning_out_of_range_reg)
        |-> tuning_event_flag_reg)
        else $error("Status change did not set event flag");

    flag_sticky_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $fell(tuning_event_flag_reg) |-> $past(data_wr)
        && $past(ahb_addr_reg) == `IOTRIM_OFS_FLAG)
        else $error("Event flag cleared without software");

    sleep_quiet_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        sleep_mode ##1 sleep_mode && !$past(data_wr) |-> $stable(trim_reg) && !tuning_irq)
        else $error("Activity during Sleep");

    range_top_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        running && ref_strobe && trim_reg == `IOTRIM_TRIM_MAX
        && verdict == iotrim_pkg::IOTRIM_TOO_SLOW
        |=> tuning_out_of_range_reg && trim_reg == `IOTRIM_TRIM_MAX)
        else $error("Trim passed the upper limit");

    lock_set_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        running && ref_strobe && verdict == iotrim_pkg::IOTRIM_IN_WINDOW && !data_wr
        |=> tuning_locked_reg)
        else $error("Lock not set inside window");

    range_clear_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        running && ref_strobe && verdict == iotrim_pkg::IOTRIM_IN_WINDOW
        |=> !tuning_out_of_range_reg)
        else $error("Out-of-range kept after lock");

endmodule

// ---- core/iotrim_defs.svh ----
// Purpose: Constants of the internal oscillator auto trim block.
// Assumes: AHB-Lite word registers, 25 MHz hclk.
// Notes:   Included by the package and the core; definitions only.
// Contract
// - Any reset leaves tuning switched off, enable bit clear.
// - While tuning is off, software writes set the 7-bit trim value.
// - Setting enable starts tuning; the trim register then belongs to hardware.
// - Enabled and not held, trim moves once per reference tick toward target.
// - While enabled, trim writes are dropped; trim reads still return it.
// - Reference select picks the USB reference tick or the secondary oscillator.
// - Locked bit sets once the oscillator count is inside the window.
// - Locked clears on loss of lock, on reset, and when disabled.
// - Out-of-range sets when trim sits at a limit and a tick pushes beyond.
// - At a limit the trim value holds; it never wraps or passes it.
// - Out-of-range clears when back in range and lock is re-established.
// - Update hold freezes trim while lock and out-of-range keep tracking.
// - Clearing update hold resumes per-tick trim updates.
// - Any change of locked or out-of-range sets the event flag.
// - With the event enable at 1, the event flag raises the interrupt.
// - The event flag holds until software clears it; hardware never clears it.
// - In Sleep tuning stops: no trim updates and no interrupt.
// - Reference select 1 is the USB reference, 0 the secondary oscillator.
// - Control bits: enable 7, hold 6, select 4, locked 3, out-of-range 1.
`ifndef IOTRIM_DEFS_SVH
`define IOTRIM_DEFS_SVH

// Register byte offsets
`define IOTRIM_OFS_CONTROL   6'h00
`define IOTRIM_OFS_TRIM      6'h04
`define IOTRIM_OFS_FLAG      6'h08
`define IOTRIM_OFS_IRQ_EN    6'h0C

// Control register fields
`define IOTRIM_BIT_ENABLE    7
`define IOTRIM_BIT_HOLD      6
`define IOTRIM_BIT_SELECT    4
`define IOTRIM_BIT_LOCKED    3
`define IOTRIM_BIT_RANGE     1
// Flag and enable registers keep their bit in position 7
`define IOTRIM_BIT_EVENT     7

// Reset and limits of the trim value
`define IOTRIM_TRIM_W        7
`define IOTRIM_TRIM_RESET    7'h00
`define IOTRIM_TRIM_MIN      7'h00
`define IOTRIM_TRIM_MAX      7'h7F

// Oscillator edges expected per reference period and lock tolerance
`define IOTRIM_CNT_W         12
`define IOTRIM_USB_TARGET    12'h7D0
`define IOTRIM_USB_TOL       12'h004
`define IOTRIM_SEC_TARGET    12'h03D
`define IOTRIM_SEC_TOL       12'h001

`endif

// ---- core/iotrim_pkg.sv ----
// Purpose: Types of the internal oscillator auto trim block.
// Assumes: Constants come from iotrim_defs.svh.
// Notes:   No imports; users write iotrim_pkg::name.
`include "iotrim_defs.svh"

package iotrim_pkg;
    typedef logic [`IOTRIM_TRIM_W-1:0] iotrim_trim_t;
    typedef logic [`IOTRIM_CNT_W-1:0]  iotrim_cnt_t;
    // Outcome of comparing one reference period
    typedef enum logic [1:0] {
        IOTRIM_IN_WINDOW,
        IOTRIM_TOO_SLOW,
        IOTRIM_TOO_FAST
    } iotrim_verdict_e;
endpackage

// ---- test/iotrim_ref_model.sv ----
// Purpose: Oscillator and reference sources around the auto trim block.
// Assumes: Oscillator period falls as the trim value rises.
// Notes:   target_trim sets where the pulse count meets the secondary lock window.
`timescale 1ns/1ps

module iotrim_ref_model #(
    parameter int OSC_NS      = 500,
    parameter int STEP_NS     = 20,
    parameter int SEC_HALF_NS = 15250,
    parameter int USB_HALF_NS = 4000
) (
    // Scenario controls
    input  int              target_trim,
    input  wire logic       run_usb,
    input  wire logic       run_sec,
    // Trim from the block
    input  wire logic [6:0] trim_value,
    // Pins toward the block
    output logic            usb_ref_tick,
    output logic            secondary_oscillator,
    output logic            osc_div_tick
);
    ////////////////////////////////////////////////////////////////////////////
    // Divided oscillator: 61 periods per secondary tick at the target trim
    always begin : osc_gen
        int p;
        p = OSC_NS + STEP_NS * (target_trim - int'(trim_value));
        osc_div_tick = 1'b1;
        #(p / 2);
        osc_div_tick = 1'b0;
        #(p - p / 2);
    end

    // Secondary oscillator, held low while stopped; the step keeps one trim off lock
    always begin : sec_gen
        secondary_oscillator = run_sec;
        #(SEC_HALF_NS);
        secondary_oscillator = 1'b0;
        #(SEC_HALF_NS);
    end

    // USB reference, far shorter than a frame so runs stay brief
    always begin : usb_gen
        usb_ref_tick = run_usb;
        #(USB_HALF_NS);
        usb_ref_tick = 1'b0;
        #(USB_HALF_NS);
    end
endmodule

// ---- test/test_internal_osc_auto_trim.sv ----
// Purpose: Self-checking bench of the oscillator auto trim block.
// Assumes: Zero-wait AHB-Lite slave; pins come from iotrim_ref_model.
// Notes:   Status is awaited by polling the control word under a bound.
`timescale 1ns/1ps
`include "iotrim_defs.svh"

module test_internal_osc_auto_trim;
    localparam logic [31:0] A_CTL  = 32'(`IOTRIM_OFS_CONTROL);
    localparam logic [31:0] A_TRIM = 32'(`IOTRIM_OFS_TRIM);
    localparam logic [31:0] A_FLAG = 32'(`IOTRIM_OFS_FLAG);
    localparam logic [31:0] A_IEN  = 32'(`IOTRIM_OFS_IRQ_EN);
    // Bus, pins and scenario controls
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        sleep_mode = 1'b0;
    logic [6:0]  trim_value;
    logic        tuning_irq;
    logic        usb_ref_tick;
    logic        secondary_oscillator;
    logic        osc_div_tick;
    logic        run_usb = 1'b0;
    logic        run_sec = 1'b1;
    logic [31:0] r;
    int          target_trim = 4;
    int          failures = 0;
    int          total_checks = 0;

    always #20 hclk = ~hclk;

    iotrim_core iotrim_core_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .usb_ref_tick(usb_ref_tick), .secondary_oscillator(secondary_oscillator),
        .osc_div_tick(osc_div_tick), .sleep_mode(sleep_mode),
        .trim_value(trim_value), .tuning_irq(tuning_irq)
    );

    iotrim_ref_model iotrim_ref_model_i (
        .target_trim(target_trim), .run_usb(run_usb), .run_sec(run_sec),
        .trim_value(trim_value), .usb_ref_tick(usb_ref_tick),
        .secondary_oscillator(secondary_oscillator), .osc_div_tick(osc_div_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Verdict and counts, reached from the main sequence or a spent bound
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // One single word transfer; read data taken at the data-phase edge
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        int n;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= wr;
        n = 0;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
        htrans <= 2'h0;
        hwdata <= wd;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 100);
        rd = hrdata;
        if (n >= 100) begin
            failures++;
            complete_run();
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        chk(x, e);
    endtask

    // Polls control until it shows e; a spent bound ends the run
    task automatic wait_ctrl(input logic [31:0] e);
        logic [31:0] x;
        int n;
        for (n = 0; n < 400; n++) begin
            bus(1'b0, A_CTL, 32'h0, x);
            if (x === e)
                break;
            repeat (40) @(posedge hclk);
        end
        chk(x, e);
        if (n == 400)
            complete_run();
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(A_CTL, 32'h0);
        rd(A_TRIM, 32'h0);
        rd(A_FLAG, 32'h0);
        rd(A_IEN, 32'h0);
        rd(32'h10, 32'h0);
        wr(A_CTL, 32'h7F);
        rd(A_CTL, 32'h50);
        wr(A_CTL, 32'h0);
        wr(A_TRIM, 32'hFF);
        rd(A_TRIM, 32'h7F);
        chk(32'(trim_value), 32'h7F);
        wr(A_TRIM, 32'h0);
        $display("test reset and manual trim done");
        // Closed loop on the secondary reference, then the event flag
        wr(A_CTL, 32'h80);
        wr(A_TRIM, 32'h33);
        wait_ctrl(32'h88);
        rd(A_TRIM, 32'h04);
        chk(32'(hresp), 32'h0);
        rd(A_FLAG, 32'h80);
        wr(A_IEN, 32'h80);
        @(posedge hclk);
        chk(32'(tuning_irq), 32'h1);
        wr(A_FLAG, 32'h80);
        rd(A_FLAG, 32'h80);
        wr(A_FLAG, 32'h0);
        rd(A_FLAG, 32'h0);
        chk(32'(tuning_irq), 32'h0);
        wr(A_IEN, 32'h0);
        $display("test lock and event done");
        // Update hold: trim frozen, lock still tracks the drift
        wr(A_CTL, 32'hC0);
        target_trim = 8;
        wait_ctrl(32'hC0);
        rd(A_TRIM, 32'h04);
        rd(A_FLAG, 32'h80);
        wr(A_CTL, 32'h80);
        wait_ctrl(32'h88);
        rd(A_TRIM, 32'h08);
        wr(A_CTL, 32'h0);
        rd(A_CTL, 32'h0);
        $display("test update hold done");
        // Lower limit, then recovery into range
        repeat (3) @(posedge hclk);
        wr(A_TRIM, 32'h0);
        target_trim = -3;
        wr(A_CTL, 32'h80);
        wait_ctrl(32'h82);
        rd(A_TRIM, 32'h0);
        target_trim = 2;
        wait_ctrl(32'h88);
        // Upper limit
        wr(A_CTL, 32'h0);
        repeat (3) @(posedge hclk);
        wr(A_TRIM, 32'h7E);
        target_trim = 130;
        wr(A_CTL, 32'h80);
        wait_ctrl(32'h82);
        rd(A_TRIM, 32'h7F);
        $display("test trim limits done");
        // Sleep stops tuning and masks the request
        wr(A_IEN, 32'h80);
        sleep_mode <= 1'b1;
        target_trim = 112;
        repeat (2400) @(posedge hclk);
        chk(32'(tuning_irq), 32'h0);
        rd(A_TRIM, 32'h7F);
        sleep_mode <= 1'b0;
        repeat (2) @(posedge hclk);
        chk(32'(tuning_irq), 32'h1);
        wait_ctrl(32'h88);
        rd(A_TRIM, 32'h70);
        $display("test sleep done");
        // Reference select: only the USB reference runs now
        wr(A_CTL, 32'h0);
        run_sec = 1'b0;
        run_usb  = 1'b1;
        wr(A_CTL, 32'h80);
        repeat (3000) @(posedge hclk);
        rd(A_TRIM, 32'h70);
        wr(A_CTL, 32'h0);
        wr(A_CTL, 32'h10);
        rd(A_CTL, 32'h10);
        wr(A_CTL, 32'h90);
        repeat (3000) @(posedge hclk);
        bus(1'b0, A_TRIM, 32'h0, r);
        chk(32'(r > 32'h70), 32'h1);
        $display("test reference select done");
        complete_run();
    end
endmodule
